// File: hw/flbr_params.svh
// Timing-free constants for the fault log block readout.
`ifndef FLBR_PARAMS_SVH
`define FLBR_PARAMS_SVH
`define FLBR_IMAGE_LEN 9'h0FF
`define FLBR_LAST_ADDR 8'hFE
`define FLBR_FIRST_ADDR 8'h00
`define FLBR_RSVD_FIRST 8'hEE
`define FLBR_INVALID_FIRST 8'hE8
`define FLBR_INVALID_LAST 8'hED
`define FLBR_LOOP_LEN 6'h2E
`define FLBR_LOOP_TOP 6'h2D
// In-loop index of image byte 0x00; the first whole loop begins at byte 0x26.
`define FLBR_LOOP_START 6'h25
`define FLBR_RSVD_VALUE 8'h00
`define FLBR_FIFO_DEPTH 32
`define FLBR_BYTE_W 8
`endif

// File: hw/flbr_pkg.sv
// Types shared by the fault log block readout.
package flbr_pkg;
  typedef logic [7:0] flbr_byte_t;
  typedef enum logic [1:0] {
    FLBR_IDLE = 2'b00,
    FLBR_FILL = 2'b01,
    FLBR_DONE = 2'b11
  } flbr_state_e;
endpackage

// File: hw/flbr_fifo.sv
// Holds no logic: the byte FIFO module is declared beside the readout logic.

// File: hw/flbr_readout.sv
// Fault log block readout: streams the 255-byte log image to the bus engine.
`timescale 1ns/1ps
`include "flbr_params.svh"
module flbr_readout import flbr_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_block_start,
  output logic [7:0] o_log_addr,
  output logic o_log_req,
  input wire logic i_log_valid,
  input wire logic [7:0] i_log_data,
  input wire logic i_byte_req,
  output logic o_byte_valid,
  output logic [7:0] o_byte_data,
  output logic [7:0] o_byte_index,
  output logic o_byte_invalid,
  output logic o_byte_last,
  output logic [5:0] o_loop_index
);
  // ----------------------------------------------------------------
  // Fetch side
  // ----------------------------------------------------------------
  // Fetch state, the next image address and the one outstanding fetch.
  flbr_state_e state;
  logic [7:0] fetch_addr;
  logic pending;
  logic fifo_in_ready;
  logic fifo_in_valid;
  flbr_byte_t fifo_in_data;
  logic fifo_out_valid;
  flbr_byte_t fifo_out_data;
  logic [7:0] send_ptr;
  logic [5:0] loop_cnt;
  logic pop;

  // Reserved trailer bytes never touch the log store; they are zero-filled here.
  assign fifo_in_data = (fetch_addr >= `FLBR_RSVD_FIRST) ? `FLBR_RSVD_VALUE : i_log_data;
  // A byte is queued for every trailer address, or when the outstanding fetch is answered.
  assign fifo_in_valid = (state == FLBR_FILL) &&
                         ((fetch_addr >= `FLBR_RSVD_FIRST) || (pending && i_log_valid));
  // One fetch at a time: the request is a one-cycle pulse, so the log store must
  // latch it, and an answer that arrives with no fetch outstanding is ignored.
  assign o_log_req = (state == FLBR_FILL) && !pending && fifo_in_ready &&
                     (fetch_addr < `FLBR_RSVD_FIRST);
  // The store is addressed straight from the fetch pointer.
  assign o_log_addr = fetch_addr;

  // Fetch sequencer walks the image once per block read.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= FLBR_IDLE;
      fetch_addr <= 8'h00;
      pending <= 1'b0;
    end else if (i_block_start) begin
      state <= FLBR_FILL;
      fetch_addr <= `FLBR_FIRST_ADDR;
      pending <= 1'b0;
    end else begin
      unique case (state)
        FLBR_IDLE: begin
          // Nothing to fetch until a block read starts.
          pending <= 1'b0;
        end
        FLBR_FILL: begin
          if (o_log_req) begin
            pending <= 1'b1;
          end
          // Each accepted byte moves the fetch on; the last one ends the fill.
          if (fifo_in_valid && fifo_in_ready) begin
            pending <= 1'b0;
            if (fetch_addr == `FLBR_LAST_ADDR) begin
              state <= FLBR_DONE;
            end else begin
              fetch_addr <= fetch_addr + 8'h01;
            end
          end
        end
        FLBR_DONE: begin
          // Whole image queued; wait for the next block read.
          pending <= 1'b0;
        end
        // The unused code falls back to idle rather than locking up.
        default: begin
          state <= FLBR_IDLE;
          pending <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Buffer
  // ----------------------------------------------------------------
  // Thirty-two entries let the fetch side run ahead of a stalled host.
  flbr_fifo #(
    .WIDTH(`FLBR_BYTE_W),
    .DEPTH(`FLBR_FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_flush(i_block_start),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(i_byte_req),
    .o_out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Send side
  // ----------------------------------------------------------------
  // The bus engine stalls the FIFO by holding off its byte request.
  assign pop = fifo_out_valid && i_byte_req && !i_block_start;
  assign o_byte_valid = fifo_out_valid;
  assign o_byte_data = fifo_out_data;
  assign o_byte_index = send_ptr;
  assign o_loop_index = loop_cnt;
  // The last flag lets the bus engine close the block read on the final byte.
  assign o_byte_last = (send_ptr == `FLBR_LAST_ADDR);
  // Marks the truncated loop tail; the host must discard these bytes.
  assign o_byte_invalid = (send_ptr >= `FLBR_INVALID_FIRST) &&
                          (send_ptr <= `FLBR_INVALID_LAST);

  // Send pointer follows each byte handed to the bus.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      send_ptr <= 8'h00;
    end else if (i_block_start) begin
      send_ptr <= `FLBR_FIRST_ADDR;
    end else if (pop && send_ptr != `FLBR_LAST_ADDR) begin
      // The pointer parks on the last address once the image has gone out.
      send_ptr <= send_ptr + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Loop position
  // ----------------------------------------------------------------
  // In-loop index counts 45 down to 0 and wraps. The loops sit behind a log
  // header, so image byte 0x00 starts part way through a count; the index shown
  // for header bytes has no meaning and only keeps the wrap aligned.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      loop_cnt <= `FLBR_LOOP_START;
    end else if (i_block_start) begin
      loop_cnt <= `FLBR_LOOP_START;
    end else if (pop) begin
      loop_cnt <= (loop_cnt == 6'h00) ? `FLBR_LOOP_TOP : loop_cnt - 6'h01;
    end
  end
endmodule

// ----------------------------------------------------------------
// Byte buffer
// ----------------------------------------------------------------
// Queue between the log fetch and the bus engine; DEPTH must be a power of two,
// since the pointers wrap by plain overflow.
module flbr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  // One spare pointer bit tells a full buffer from an empty one.
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  // Full when the pointers differ only in the spare bit; empty when they match.
  assign o_in_ready = (wr_ptr[AW] == rd_ptr[AW]) ||
                      (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign o_out_valid = (wr_ptr != rd_ptr);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  // The head word is read without a register so a queued byte stands at once.
  assign o_out_data = mem[rd_ptr[AW-1:0]];

  // Storage is written only, never reset, to keep it a plain RAM.
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end

  // Pointers; a flush drops everything queued for an aborted read.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (i_flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + (AW+1)'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + (AW+1)'(1);
      end
    end
  end
endmodule

// File: tb/flbr_readout_monitor.sv
// Concurrent checks on the readout byte stream.
`timescale 1ns/1ps
module flbr_readout_monitor (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_block_start,
  input wire logic i_byte_req,
  input wire logic o_log_req,
  input wire logic [7:0] o_log_addr,
  input wire logic o_byte_valid,
  input wire logic [7:0] o_byte_data,
  input wire logic [7:0] o_byte_index,
  input wire logic o_byte_invalid,
  input wire logic o_byte_last,
  input wire logic [5:0] o_loop_index
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // A byte leaves only when offered, taken and not overridden by a start.
  wire logic pop = o_byte_valid && i_byte_req && !i_block_start;
  trailer_zero_a: assert property (
    o_byte_valid && o_byte_index >= 8'hEE |-> o_byte_data == 8'h00)
    else $error("Trailer byte not zero.");
  store_untouched_a: assert property (
    o_log_req |-> o_log_addr < 8'hEE)
    else $error("Trailer address fetched from the log store.");
  invalid_flag_a: assert property (
    o_byte_valid |-> o_byte_invalid == (o_byte_index inside {[8'hE8:8'hED]}))
    else $error("Invalid flag wrong.");
  last_flag_a: assert property (
    o_byte_valid |-> o_byte_last == (o_byte_index == 8'hFE))
    else $error("Last flag wrong.");
  end_of_image_a: assert property (
    pop && o_byte_last |=> !o_byte_valid)
    else $error("Byte offered past the image end.");
  index_step_a: assert property (
    pop && !o_byte_last |=> o_byte_index == $past(o_byte_index) + 8'h01)
    else $error("Index did not step by one.");
  restart_zero_a: assert property (
    i_block_start |=> !o_byte_valid ##[1:12] (o_byte_valid && o_byte_index == 8'h00))
    else $error("Read did not restart at zero.");
  loop_count_a: assert property (
    o_byte_valid |-> int'(o_loop_index) == 45 - (int'(o_byte_index) + 8) % 46)
    else $error("Loop index wrong.");
  cover property (pop && o_byte_last);
  cover property (pop && o_byte_invalid);
  cover property (i_block_start && o_byte_valid);
endmodule

// File: tb/flbr_log_model.sv
// Log store model that answers each fetch promptly or slowly.
`timescale 1ns/1ps
module flbr_log_model (
  input wire logic i_ref_clk,
  input wire logic i_slow,
  input wire logic i_req,
  input wire logic [7:0] i_addr,
  output logic o_valid = 1'b0,
  output logic [7:0] o_data = 8'h00
);
  logic [2:0] cnt = 3'h0;
  logic busy = 1'b0;
  logic [7:0] addr = 8'h00;
  // The request is a one-cycle pulse, so it is latched; a new one replaces any
  // fetch still in flight, as after a restarted block read.
  // Data toggles between answers so a stale byte is never mistaken for news.
  always @(posedge i_ref_clk) begin
    o_valid <= 1'b0;
    o_data <= ~o_data;
    if (i_req) begin
      busy <= 1'b1;
      addr <= i_addr;
      cnt <= 3'h0;
    end else if (busy) begin
      cnt <= cnt + 3'h1;
      if (cnt >= (i_slow ? 3'h5 : 3'h0)) begin
        o_valid <= 1'b1;
        o_data <= addr ^ 8'hA5;
        busy <= 1'b0;
      end
    end
  end
endmodule

// File: tb/flbr_readout_bench.sv
// Self-checking bench for the fault log block readout.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
  $display("FAIL %0t got %h exp %h", $time, a, b); end end
module flbr_readout_bench;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_block_start = 1'b0, i_byte_req = 1'b0;
  logic slow = 1'b0, o_log_req, i_log_valid, o_byte_valid, o_byte_invalid, o_byte_last;
  logic [7:0] o_log_addr, i_log_data, o_byte_data, o_byte_index;
  logic [5:0] o_loop_index;
  int fail_count = 0, samples_checked = 0;
  flbr_readout dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_block_start(i_block_start),
    .o_log_addr(o_log_addr), .o_log_req(o_log_req), .i_log_valid(i_log_valid),
    .i_log_data(i_log_data), .i_byte_req(i_byte_req), .o_byte_valid(o_byte_valid),
    .o_byte_data(o_byte_data), .o_byte_index(o_byte_index), .o_byte_invalid(o_byte_invalid),
    .o_byte_last(o_byte_last), .o_loop_index(o_loop_index));
  flbr_log_model store (.i_ref_clk(i_ref_clk), .i_slow(slow), .i_req(o_log_req),
    .i_addr(o_log_addr), .o_valid(i_log_valid), .o_data(i_log_data));
  task automatic stop_test;
    $display("Checked %0d, failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic start;
    @(posedge i_ref_clk) i_block_start <= 1'b1;
    @(posedge i_ref_clk) i_block_start <= 1'b0;
    @(negedge i_ref_clk);
  endtask
  // Waits for a byte, judges it, then takes it; the gap stalls the host side.
  task automatic pop(input logic [7:0] i);
    int n = 0;
    while (o_byte_valid !== 1'b1 && n < 99) begin
      @(negedge i_ref_clk);
      n++;
    end
    `CHK(o_byte_index, i)
    `CHK(o_byte_data, i >= 8'hEE ? 8'h00 : i ^ 8'hA5)
    `CHK(o_byte_invalid, i >= 8'hE8 && i <= 8'hED)
    `CHK(o_loop_index, 6'(45 - (i + 8) % 46))
    `CHK(o_byte_last, i == 8'hFE)
    @(posedge i_ref_clk) i_byte_req <= 1'b1;
    @(posedge i_ref_clk) i_byte_req <= 1'b0;
    @(negedge i_ref_clk);
  endtask
  // Whole image after a long stall, so the buffer fills before draining.
  task automatic whole_image;
    start();
    repeat (100) @(negedge i_ref_clk);
    for (int i = 0; i < 255; i++) pop(8'(i));
    @(posedge i_ref_clk) i_byte_req <= 1'b1;
    repeat (4) @(negedge i_ref_clk);
    `CHK(o_byte_valid, 1'b0)
    @(posedge i_ref_clk) i_byte_req <= 1'b0;
  endtask
  // A new start mid-read with a slow store must begin again at byte zero.
  task automatic restart_read;
    @(posedge i_ref_clk) slow <= 1'b1;
    start();
    for (int i = 0; i < 6; i++) pop(8'(i));
    start();
    for (int i = 0; i < 3; i++) pop(8'(i));
  endtask
  initial forever #5 i_ref_clk = ~i_ref_clk;
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(negedge i_ref_clk);
    whole_image();
    restart_read();
    stop_test();
  end
  // A hang counts as a failure.
  initial begin
    #200us;
    fail_count++;
    stop_test();
  end
endmodule
bind flbr_readout flbr_readout_monitor mon (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_block_start(i_block_start), .i_byte_req(i_byte_req), .o_log_req(o_log_req),
  .o_log_addr(o_log_addr), .o_byte_valid(o_byte_valid), .o_byte_data(o_byte_data),
  .o_byte_index(o_byte_index), .o_byte_invalid(o_byte_invalid), .o_byte_last(o_byte_last),
  .o_loop_index(o_loop_index));
